// >>> rtl/rst_ctrl_pkg.sv
// constants, offsets and types for the reset and stop recovery controller
// assumes a single core clock; everything else arrives through synchronisers
package rst_ctrl_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [11:0] WDT_CTRL_OFS = 12'hFF0;
	localparam logic [11:0] OPTION_OFS = 12'hFF4;
	localparam logic [11:0] WAKE_MASK_OFS = 12'hFF8;
	localparam logic [11:0] DBG_CTRL_OFS = 12'hFFC;

	// cause flags sit in bits 7:4 of the watchdog control register
	localparam int FLAG_LSB = 4;
	localparam int FLAG_PIN = 0;
	localparam int FLAG_WDT = 1;
	localparam int FLAG_STOP = 2;
	localparam int FLAG_POR = 3;
	localparam int DBG_RESET_BIT = 1;
	localparam int OPT_WDT_RESET_BIT = 0;

	// values after reset
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic OPTION_RESET = 1'b1;
	localparam logic [7:0] WAKE_MASK_RESET = 8'h00;
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;

	// ----------------------------------------------------------------
	// hold times
	// ----------------------------------------------------------------
	localparam logic [9:0] SYS_OSC_CYCLES = 10'h202;
	localparam logic [9:0] SHORT_OSC_CYCLES = 10'h042;
	localparam logic [4:0] SYS_CLK_CYCLES = 5'h10;
	localparam logic [9:0] SYS_OSC_LAST = SYS_OSC_CYCLES - 10'h001;
	localparam logic [9:0] SHORT_OSC_LAST = SHORT_OSC_CYCLES - 10'h001;
	localparam logic [3:0] SYS_CLK_LAST = 4'(SYS_CLK_CYCLES - 5'h01);

	// ----------------------------------------------------------------
	// synchroniser bank layout
	// ----------------------------------------------------------------
	localparam int SYNC_W = 14;
	localparam int S_OSC = 0;
	localparam int S_PIN_N = 1;
	localparam int S_DBG = 2;
	localparam int S_SUP = 3;
	localparam int S_BOD = 4;
	localparam int S_WDT = 5;
	localparam int S_WAKE = 6;
	localparam logic [13:0] SYNC_INIT = 14'h0006;

	typedef enum logic [2:0] {ST_RUN, ST_HOLD, ST_OSC, ST_PINWAIT, ST_SYS} state_t;
	typedef enum logic [2:0] {KIND_SYSTEM, KIND_SHORT, KIND_STOP, KIND_DEBUG} kind_t;

endpackage

// >>> rtl/sync_bank.sv
// two-flop synchronisers, one per bit, for inputs from outside the clock
// assumes each input bit is an independent level; no bus coherence
`timescale 1ns/100ps
`default_nettype none
module sync_bank #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk_i,              // core clock
	input wire logic srst_i,             // synchronous reset
	input wire logic clk_en_i,           // freezes the stages when low
	input wire logic [WIDTH-1:0] d_i,    // raw asynchronous levels
	output logic [WIDTH-1:0] q_o         // synchronised levels
);
	// ----------------------------------------------------------------
	// per-bit stages
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_reg;
			logic sync_reg;
			// first stage feeds only the second stage
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					meta_reg <= INIT[i];
					sync_reg <= INIT[i];
				end else if (clk_en_i) begin
					meta_reg <= d_i[i];
					sync_reg <= meta_reg;
				end
			end
			assign q_o[i] = sync_reg;
		end
	endgenerate
endmodule
`default_nettype wire

// >>> rtl/reset_stop_ctrl.sv
// reset and stop mode recovery sequencer with an Avalon-MM register slave
// assumes the watchdog oscillator, supply monitor, pins and watchdog
// time-out are asynchronous levels; stop_mode_i comes from the core clock
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module reset_stop_ctrl (
	input wire logic core_clk_i,            // 10 MHz core clock
	input wire logic srst_i,                // synchronous reset, high
	input wire logic clk_en_i,              // freezes all state when low
	input wire logic supply_ok_i,           // supply above power-on level
	input wire logic brownout_detect_i,     // supply below brown-out level
	input wire logic wdt_timeout_i,         // watchdog time-out level
	input wire logic reset_pin_n_i,         // external reset pin, low
	input wire logic debug_pin_i,           // debug pin level
	input wire logic [7:0] wake_pin_i,      // stop mode wake pins
	input wire logic osc_clk_i,             // watchdog oscillator
	input wire logic stop_mode_i,           // core is in stop mode
	input wire logic [11:0] avs_address_i,  // byte address
	input wire logic avs_read_i,            // read request
	input wire logic avs_write_i,           // write request
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [31:0] avs_readdata_o,     // read data
	output logic avs_waitrequest_o,         // stall, high
	output logic cpu_reset_o,               // core held in reset
	output logic periph_reset_o,            // peripherals held in reset
	output logic debugger_reset_o,          // debugger held in reset
	output logic sysclk_run_o,              // system clock enable
	output logic vector_fetch_o,            // pulse: fetch reset vector
	output logic [15:0] vector_addr_o       // reset vector address
);
	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	logic [13:0] sync_q;
	logic osc_s, pin_n_s, dbg_s, sup_s, bod_s, wdt_s;
	logic [7:0] wake_s;

	// every outside level crosses two flops before use
	sync_bank #(
		.WIDTH(rst_ctrl_pkg::SYNC_W),
		.INIT(rst_ctrl_pkg::SYNC_INIT)
	) u_sync (
		.clk_i(core_clk_i),
		.srst_i(srst_i),
		.clk_en_i(clk_en_i),
		.d_i({wake_pin_i, wdt_timeout_i, brownout_detect_i, supply_ok_i,
			debug_pin_i, reset_pin_n_i, osc_clk_i}),
		.q_o(sync_q)
	);

	assign osc_s = sync_q[rst_ctrl_pkg::S_OSC];
	assign pin_n_s = sync_q[rst_ctrl_pkg::S_PIN_N];
	assign dbg_s = sync_q[rst_ctrl_pkg::S_DBG];
	assign sup_s = sync_q[rst_ctrl_pkg::S_SUP];
	assign bod_s = sync_q[rst_ctrl_pkg::S_BOD];
	assign wdt_s = sync_q[rst_ctrl_pkg::S_WDT];
	assign wake_s = sync_q[rst_ctrl_pkg::S_WAKE +: 8];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rst_ctrl_pkg::state_t state_reg, state_next;
	rst_ctrl_pkg::kind_t kind_reg, kind_next;
	logic [3:0] pend_reg, pend_next;
	logic [3:0] flags_reg, flags_next;
	logic [9:0] osc_cnt_reg, osc_cnt_next;
	logic [3:0] sys_cnt_reg, sys_cnt_next;
	logic osc_prev_reg, wdt_prev_reg;
	logic [7:0] wake_prev_reg;
	logic opt_reg, dbg_req_reg;
	logic [7:0] wake_mask_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic cpu_rst_reg, periph_rst_reg, dbg_rst_reg, sysclk_reg, fetch_reg;
	logic [15:0] vec_reg;

	// ----------------------------------------------------------------
	// event detection and request decode
	// ----------------------------------------------------------------
	logic osc_tick, wdt_rise, wake_edge, pin_low, in_run, supply_bad;
	logic stop_sys_req, stop_rec_req, dbg_sys_req, short_req, any_req;
	logic [9:0] osc_last;
	logic exiting, entering, cfg_load;

	// edges only look at the second synchroniser stage
	assign osc_tick = osc_s & ~osc_prev_reg;
	assign wdt_rise = wdt_s & ~wdt_prev_reg;
	assign wake_edge = |((wake_s ^ wake_prev_reg) & wake_mask_reg);
	assign pin_low = ~pin_n_s;
	assign in_run = (state_reg == rst_ctrl_pkg::ST_RUN);

	// supply faults override everything; brown-out sleeps in stop
	assign supply_bad = ~sup_s | (bod_s & ~stop_mode_i);

	// classify by mode and source
	assign stop_sys_req = in_run & stop_mode_i & (pin_low | ~dbg_s);
	assign stop_rec_req = in_run & stop_mode_i & (wdt_rise | wake_edge);
	assign dbg_sys_req = in_run & ~stop_mode_i & dbg_req_reg;
	assign short_req = in_run & ~stop_mode_i &
		(pin_low | (wdt_rise & opt_reg));
	assign any_req = stop_sys_req | stop_rec_req | dbg_sys_req | short_req;

	// only a short reset uses the shorter oscillator count
	assign osc_last = (kind_reg == rst_ctrl_pkg::KIND_SHORT) ?
		rst_ctrl_pkg::SHORT_OSC_LAST : rst_ctrl_pkg::SYS_OSC_LAST;

	assign exiting = ~in_run & (state_next == rst_ctrl_pkg::ST_RUN);
	assign entering = in_run & (state_next != rst_ctrl_pkg::ST_RUN);
	// stop recovery leaves the option and wake mask registers alone
	assign cfg_load = (state_next != rst_ctrl_pkg::ST_RUN) &
		(kind_next != rst_ctrl_pkg::KIND_STOP);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// supply fault is checked first so it wins in every state
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		pend_next = pend_reg;
		osc_cnt_next = osc_cnt_reg;
		sys_cnt_next = sys_cnt_reg;
		if (supply_bad) begin
			state_next = rst_ctrl_pkg::ST_HOLD;
			kind_next = rst_ctrl_pkg::KIND_SYSTEM;
			pend_next = 4'h8;
			osc_cnt_next = 10'h000;
		end else begin
			case (state_reg)
				rst_ctrl_pkg::ST_RUN: begin
					osc_cnt_next = 10'h000;
					if (stop_sys_req) begin
						kind_next = rst_ctrl_pkg::KIND_SYSTEM;
						pend_next = {2'b01, 1'b0, pin_low};
					end else if (stop_rec_req) begin
						kind_next = rst_ctrl_pkg::KIND_STOP;
						pend_next = {2'b01, wdt_rise, 1'b0};
					end else if (dbg_sys_req) begin
						kind_next = rst_ctrl_pkg::KIND_DEBUG;
						pend_next = {2'b00, wdt_rise & opt_reg, pin_low};
					end else begin
						kind_next = rst_ctrl_pkg::KIND_SHORT;
						pend_next = {2'b00, wdt_rise & opt_reg, pin_low};
					end
					if (any_req) begin
						state_next = rst_ctrl_pkg::ST_OSC;
					end else begin
						kind_next = kind_reg;
						pend_next = pend_reg;
					end
				end
				rst_ctrl_pkg::ST_HOLD: begin
					// supply has qualified: start the oscillator count
					state_next = rst_ctrl_pkg::ST_OSC;
				end
				rst_ctrl_pkg::ST_OSC: begin
					if (osc_tick) begin
						if (osc_cnt_reg == osc_last) begin
							sys_cnt_next = 4'h0;
							state_next = pin_low ? rst_ctrl_pkg::ST_PINWAIT :
								rst_ctrl_pkg::ST_SYS;
						end else begin
							osc_cnt_next = osc_cnt_reg + 10'h001;
						end
					end
				end
				rst_ctrl_pkg::ST_PINWAIT: begin
					// pin held past the count: leave as soon as it rises
					if (!pin_low) begin
						state_next = rst_ctrl_pkg::ST_RUN;
					end
				end
				rst_ctrl_pkg::ST_SYS: begin
					if (sys_cnt_reg == rst_ctrl_pkg::SYS_CLK_LAST) begin
						state_next = rst_ctrl_pkg::ST_RUN;
					end else begin
						sys_cnt_next = sys_cnt_reg + 4'h1;
					end
				end
				default: begin
					state_next = rst_ctrl_pkg::ST_HOLD;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic bus_req, rd_take, wr_take;
	logic hit_ctrl, hit_opt, hit_wake, hit_dbg;
	logic [31:0] rdata_mux;

	assign bus_req = avs_read_i | avs_write_i;
	// the request completes in the cycle that waitrequest is low
	assign rd_take = avs_read_i & ~wait_reg;
	assign wr_take = avs_write_i & ~wait_reg & avs_byteenable_i[0];
	assign hit_ctrl = (avs_address_i == rst_ctrl_pkg::WDT_CTRL_OFS);
	assign hit_opt = (avs_address_i == rst_ctrl_pkg::OPTION_OFS);
	assign hit_wake = (avs_address_i == rst_ctrl_pkg::WAKE_MASK_OFS);
	assign hit_dbg = (avs_address_i == rst_ctrl_pkg::DBG_CTRL_OFS);
	// unmapped addresses read as zero and ignore writes
	assign rdata_mux = hit_ctrl ? {24'h000000, flags_reg, 4'h0} :
		hit_opt ? {31'h00000000, opt_reg} :
		hit_wake ? {24'h000000, wake_mask_reg} :
		hit_dbg ? {30'h00000000, dbg_req_reg, 1'b0} : 32'h00000000;

	// reading clears only the flags that were returned, so a flag set
	// between sample and completion survives; a set always wins
	assign flags_next = exiting ? pend_reg :
		(rd_take & hit_ctrl) ?
		(flags_reg & ~rdata_reg[rst_ctrl_pkg::FLAG_LSB +: 4]) : flags_reg;

	// ----------------------------------------------------------------
	// sequencer and edge registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_reg <= rst_ctrl_pkg::ST_HOLD;
			kind_reg <= rst_ctrl_pkg::KIND_SYSTEM;
			pend_reg <= 4'h8;
			osc_cnt_reg <= 10'h000;
			sys_cnt_reg <= 4'h0;
			flags_reg <= rst_ctrl_pkg::FLAGS_RESET;
			osc_prev_reg <= 1'b0;
			wdt_prev_reg <= 1'b0;
			wake_prev_reg <= 8'h00;
		end else if (clk_en_i) begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			pend_reg <= pend_next;
			osc_cnt_reg <= osc_cnt_next;
			sys_cnt_reg <= sys_cnt_next;
			flags_reg <= flags_next;
			osc_prev_reg <= osc_s;
			wdt_prev_reg <= wdt_s;
			wake_prev_reg <= wake_s;
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// a reset reload beats a software write in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (srst_i || (clk_en_i && cfg_load)) begin
			opt_reg <= rst_ctrl_pkg::OPTION_RESET;
			wake_mask_reg <= rst_ctrl_pkg::WAKE_MASK_RESET;
		end else if (clk_en_i && wr_take) begin
			if (hit_opt) begin
				opt_reg <= avs_writedata_i[rst_ctrl_pkg::OPT_WDT_RESET_BIT];
			end
			if (hit_wake) begin
				wake_mask_reg <= avs_writedata_i[7:0];
			end
		end
	end

	// the debugger request bit is consumed when any reset starts
	always_ff @(posedge core_clk_i) begin
		if (srst_i || (clk_en_i && entering)) begin
			dbg_req_reg <= 1'b0;
		end else if (clk_en_i && wr_take && hit_dbg) begin
			dbg_req_reg <= avs_writedata_i[rst_ctrl_pkg::DBG_RESET_BIT];
		end
	end

	// one wait cycle per access; read data loaded during it
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else if (clk_en_i) begin
			wait_reg <= ~(bus_req & wait_reg);
			if (avs_read_i && wait_reg) begin
				rdata_reg <= rdata_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs, aligned with state_reg
	// ----------------------------------------------------------------
	// clock held off in hold and oscillator phases, and in stop mode while in run
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cpu_rst_reg <= 1'b1;
			periph_rst_reg <= 1'b1;
			dbg_rst_reg <= 1'b1;
			sysclk_reg <= 1'b0;
			fetch_reg <= 1'b0;
			vec_reg <= rst_ctrl_pkg::RESET_VECTOR_ADDR;
		end else if (clk_en_i) begin
			cpu_rst_reg <= (state_next != rst_ctrl_pkg::ST_RUN);
			periph_rst_reg <= cfg_load;
			dbg_rst_reg <= cfg_load & (kind_next != rst_ctrl_pkg::KIND_DEBUG);
			sysclk_reg <= (state_next == rst_ctrl_pkg::ST_SYS) |
				(state_next == rst_ctrl_pkg::ST_PINWAIT) |
				((state_next == rst_ctrl_pkg::ST_RUN) & ~stop_mode_i);
			fetch_reg <= exiting;
			vec_reg <= rst_ctrl_pkg::RESET_VECTOR_ADDR;
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign cpu_reset_o = cpu_rst_reg;
	assign periph_reset_o = periph_rst_reg;
	assign debugger_reset_o = dbg_rst_reg;
	assign sysclk_run_o = sysclk_reg;
	assign vector_fetch_o = fetch_reg;
	assign vector_addr_o = vec_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_osc_early;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && state_reg == rst_ctrl_pkg::ST_OSC && !supply_bad &&
			osc_cnt_reg != osc_last) |=> state_reg == rst_ctrl_pkg::ST_OSC;
	endproperty
	a_osc_early: assert property (p_osc_early)
		else $error("oscillator phase ended early");

	property p_short_len;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && state_reg == rst_ctrl_pkg::ST_OSC && osc_tick &&
			!supply_bad && kind_reg == rst_ctrl_pkg::KIND_SHORT &&
			osc_cnt_reg == rst_ctrl_pkg::SHORT_OSC_LAST) |=>
			sysclk_run_o && state_reg != rst_ctrl_pkg::ST_OSC;
	endproperty
	a_short_len: assert property (p_short_len)
		else $error("short reset did not leave oscillator phase at 66");

	property p_sys_phase;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && state_reg == rst_ctrl_pkg::ST_SYS && !supply_bad &&
			sys_cnt_reg != 4'hF) |=> cpu_reset_o && sysclk_run_o &&
			state_reg == rst_ctrl_pkg::ST_SYS;
	endproperty
	a_sys_phase: assert property (p_sys_phase)
		else $error("core released before 16 clocks");

	property p_supply;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && supply_bad) |=> cpu_reset_o && !sysclk_run_o &&
			kind_reg == rst_ctrl_pkg::KIND_SYSTEM;
	endproperty
	a_supply: assert property (p_supply)
		else $error("supply fault did not force system reset");

	property p_pin_hold;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && pin_low) |=> cpu_reset_o;
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("reset released while pin low");

	property p_vector;
		@(posedge core_clk_i) disable iff (srst_i)
		$fell(cpu_reset_o) |-> vector_fetch_o &&
			vector_addr_o == rst_ctrl_pkg::RESET_VECTOR_ADDR;
	endproperty
	a_vector: assert property (p_vector)
		else $error("no vector fetch at release");

	property p_por_flag;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && exiting && pend_reg[rst_ctrl_pkg::FLAG_POR]) |=>
			flags_reg[rst_ctrl_pkg::FLAG_POR];
	endproperty
	a_por_flag: assert property (p_por_flag)
		else $error("power-up flag not set");

	property p_wdt_opt;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && in_run && !stop_mode_i && wdt_rise && !opt_reg &&
			!pin_low && !dbg_req_reg && !supply_bad) |=> !cpu_reset_o;
	endproperty
	a_wdt_opt: assert property (p_wdt_opt)
		else $error("watchdog reset with option cleared");

	property p_bod_stop;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && in_run && stop_mode_i && sup_s && !any_req) |=>
			!cpu_reset_o;
	endproperty
	a_bod_stop: assert property (p_bod_stop)
		else $error("brown-out acted in stop mode");

	property p_stop_flag;
		@(posedge core_clk_i) disable iff (srst_i)
		(clk_en_i && exiting && kind_reg == rst_ctrl_pkg::KIND_STOP) |=>
			flags_reg[rst_ctrl_pkg::FLAG_STOP] && !periph_reset_o;
	endproperty
	a_stop_flag: assert property (p_stop_flag)
		else $error("stop recovery flag missing");
endmodule
`default_nettype wire

// >>> tb/reset_src_model.sv
// far-side model: watchdog oscillator and supply monitor
// assumes a 10 MHz core clock; oscillator runs at a quarter of it
`timescale 1ns/100ps
`default_nettype none
module reset_src_model (
	input wire logic core_clk_i, // core clock
	input wire logic power_good_i, // bench asks for a good supply
	output logic osc_clk_o, // oscillator level
	output logic supply_ok_o // supply above power-on level
);
	// ----------------------------------------------------------------
	// oscillator
	// ----------------------------------------------------------------
	// free-running divider: high and low two core cycles each, and it
	// keeps running through reset so hold counts can advance
	logic [1:0] div_reg = 2'h0;
	always_ff @(posedge core_clk_i) begin
		div_reg <= div_reg + 2'h1;
	end
	assign osc_clk_o = div_reg[1];
	assign supply_ok_o = power_good_i;
endmodule
`default_nettype wire

// >>> tb/reset_stop_ctrl_tb.sv
// self-checking bench for the reset and stop recovery sequencer
// assumes the oscillator model runs at a quarter of the core clock
`timescale 1ns/100ps
`default_nettype none
module reset_stop_ctrl_tb;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic pwr = 1'b0;
	logic brownout_detect_i = 1'b0;
	logic wdt_timeout_i = 1'b0;
	logic reset_pin_n_i = 1'b1;
	logic [7:0] wake_pin_i = 8'h00;
	logic debug_pin_i = 1'b1;
	logic stop_mode_i = 1'b0;
	logic [11:0] avs_address_i = 12'h000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, cpu_reset_o, vector_fetch_o, osc_clk_i;
	logic supply_ok_i;
	logic periph_reset_o, debugger_reset_o, sysclk_run_o;
	logic [15:0] vector_addr_o;
	logic [31:0] exp_q[$];
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	int w = 0;
	logic [7:0] mask;
	reset_src_model src (.core_clk_i, .power_good_i(pwr),
		.osc_clk_o(osc_clk_i), .supply_ok_o(supply_ok_i));
	reset_stop_ctrl dut (.core_clk_i, .srst_i, .clk_en_i(1'b1),
		.supply_ok_i, .brownout_detect_i, .wdt_timeout_i, .reset_pin_n_i,
		.debug_pin_i, .wake_pin_i, .osc_clk_i, .stop_mode_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
		.cpu_reset_o, .periph_reset_o, .debugger_reset_o,
		.sysclk_run_o, .vector_fetch_o, .vector_addr_o);
	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end
	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hold everything until waitrequest is sampled low; reads note d
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		if (w)
			avs_write_i <= 1'b1;
		else begin
			avs_read_i <= 1'b1;
			exp_q.push_back(d);
		end
		do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	// waits for reset to start, then times the hold from its rise;
	// rk is the expected {periph_reset_o, debugger_reset_o} while held
	task automatic hold(input int osc, input logic [1:0] rk);
		int n;
		int k;
		n = 0;
		k = 0;
		while (cpu_reset_o !== 1'b1 && n < 20) begin
			@(posedge core_clk_i);
			n++;
		end
		check("reset_kind", {30'h0, rk},
			{30'h0, periph_reset_o, debugger_reset_o});
		check("sysclk_in_osc", 32'h0, {31'h0, sysclk_run_o});
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
			if (cpu_reset_o === 1'b1 && sysclk_run_o === 1'b1)
				k++;
		end while (cpu_reset_o !== 1'b0 && n < 3000);
		check("sys_clk_phase", {27'h0, rst_ctrl_pkg::SYS_CLK_CYCLES}, k);
		check("hold", osc * 4 + 12,
			(n >= osc * 4 + 12 && n <= osc * 4 + 24) ? osc * 4 + 12 : n);
		check("vector_fetch", 32'h1, {31'h0, vector_fetch_o});
		check("vector_addr", 32'h2, {16'h0, vector_addr_o});
	endtask
	// read monitor: oldest note against the data at the completing edge
	always @(posedge core_clk_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
			check("readdata", exp_q.pop_front(), avs_readdata_o);
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h6b20b4dc));
		mask = 8'h01 << ($urandom % 8);
		repeat (5) @(posedge core_clk_i);
		srst_i <= 1'b0;
		pwr <= 1'b1;
		hold(514, 2'b11);
		bus(1'b0, 12'hFF0, 32'h80);
		bus(1'b0, 12'hFF0, 32'h00);
		bus(1'b0, 12'hFF4, 32'h01);
		bus(1'b0, 12'h000, 32'h00);
		$display("test power_up done");
		bus(1'b1, 12'hFF8, {24'h0, mask});
		reset_pin_n_i <= 1'b0;
		fork
			hold(66, 2'b11);
			begin
				repeat (10) @(posedge core_clk_i);
				reset_pin_n_i <= 1'b1;
			end
		join
		bus(1'b0, 12'hFF0, 32'h10);
		bus(1'b0, 12'hFF8, 32'h00);
		$display("test pin_reset done");
		wdt_timeout_i <= 1'b1;
		hold(66, 2'b11);
		wdt_timeout_i <= 1'b0;
		bus(1'b0, 12'hFF0, 32'h20);
		bus(1'b1, 12'hFF4, 32'h00);
		wdt_timeout_i <= 1'b1;
		repeat (40) @(posedge core_clk_i);
		check("cpu_reset", 32'h0, {31'h0, cpu_reset_o});
		wdt_timeout_i <= 1'b0;
		bus(1'b1, 12'hFFC, 32'h02);
		hold(514, 2'b10);
		bus(1'b0, 12'hFF4, 32'h01);
		$display("test watchdog_debugger done");
		bus(1'b1, 12'hFF8, {24'h0, mask});
		stop_mode_i <= 1'b1;
		brownout_detect_i <= 1'b1;
		repeat (20) @(posedge core_clk_i);
		check("cpu_reset", 32'h0, {31'h0, cpu_reset_o});
		wake_pin_i <= mask;
		hold(514, 2'b00);
		brownout_detect_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		stop_mode_i <= 1'b0;
		bus(1'b0, 12'hFF0, 32'h40);
		bus(1'b0, 12'hFF8, {24'h0, mask});
		$display("test stop_recovery done");
		// in stop, a low debug pin is a full system reset
		debug_pin_i <= 1'b0;
		stop_mode_i <= 1'b1;
		fork
			hold(514, 2'b11);
			begin
				repeat (10) @(posedge core_clk_i);
				debug_pin_i <= 1'b1;
			end
		join
		stop_mode_i <= 1'b0;
		bus(1'b0, 12'hFF0, 32'h40);
		bus(1'b0, 12'hFF8, 32'h00);
		$display("test stop_debug_pin done");
		// a brief brown-out while running restarts a full system reset
		brownout_detect_i <= 1'b1;
		@(posedge core_clk_i);
		brownout_detect_i <= 1'b0;
		hold(514, 2'b11);
		bus(1'b0, 12'hFF0, 32'h80);
		$display("test brownout done");
		// pin held past the short count: release follows the pin 4 cycles later, with no system clock phase
		reset_pin_n_i <= 1'b0;
		repeat (400) @(posedge core_clk_i);
		check("pin_wait", 32'h3, {30'h0, cpu_reset_o, sysclk_run_o});
		reset_pin_n_i <= 1'b1;
		w = 0;
		do begin
			@(posedge core_clk_i);
			w++;
		end while (cpu_reset_o !== 1'b0 && w < 100);
		check("pin_exit", 32'h4, w);
		bus(1'b0, 12'hFF0, 32'h10);
		$display("test pin_hold done");
		give_verdict();
	end
endmodule
`default_nettype wire
